// ===== rtl/align_pkg.sv
package align_pkg;

  // Sampling-clock cycles per frame and frames per multiframe (K)
  localparam int FRAME_CYC_DEF    = 2;
  localparam int K_DEF            = 16;
  // Least SYSREF high time, in frames
  localparam int MIN_PULSE_FRAMES = 2;
  // Quiet frames on the gated SYSREF that close a burst
  localparam int BURST_GAP_FRAMES = 64;

  localparam int CNT_W  = 8;
  localparam int STAT_W = 8;
  localparam int GAP_W  = 16;

  localparam logic [CNT_W-1:0]  POS_RST   = 8'h00;
  localparam logic              START_RST = 1'b1;
  localparam logic [STAT_W-1:0] STAT_RST  = 8'h00;
  localparam logic [STAT_W-1:0] STAT_MAX  = 8'hFF;
  localparam logic [GAP_W-1:0]  GAP_RST   = 16'h0000;

  typedef enum logic [1:0] {
    PH_DEFAULT,
    PH_ESTABLISHED,
    PH_REALIGNED
  } phase_state_t;

  typedef enum logic [1:0] {
    LINK_DOWN,
    LINK_WAIT,
    LINK_UP
  } link_state_t;

endpackage : align_pkg

// ===== rtl/align_if.sv
`timescale 1ns/1ps
interface align_if #(
  parameter int CNT_W = align_pkg::CNT_W
);
  logic             edge_pulse;
  logic             gated_level;
  logic             gate_rise_high;
  logic             load;
  logic [CNT_W-1:0] cyc_pos;
  logic [CNT_W-1:0] frame_pos;
  logic             frame_start;
  logic             lmfc_start;

  modport det (output edge_pulse, output gated_level, output gate_rise_high);
  modport cnt (input load, output cyc_pos, output frame_pos, output frame_start, output lmfc_start);
  modport ctl (
    input  edge_pulse,
    input  gated_level,
    input  gate_rise_high,
    input  cyc_pos,
    input  frame_pos,
    input  frame_start,
    input  lmfc_start,
    output load
  );
endinterface : align_if

// ===== rtl/sysref_edge_detect.sv
`timescale 1ns/1ps
module sysref_edge_detect (
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  input  wire logic sysref_i,
  input  wire logic gate_en_i,
  align_if.det      ifc
);

  logic sync1_reg;
  logic sync2_reg;
  logic gate_reg;
  logic gated_reg;
  logic edge_reg;
  logic rise_high_reg;
  logic gated_next;

  // Pin is asynchronous to the sampling clock
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end else begin
      sync1_reg <= sysref_i;
      sync2_reg <= sync1_reg;
    end
  end

  assign gated_next = sync2_reg & gate_en_i;

  // Opening the gate on a high input looks like a rising edge
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gate_reg      <= 1'b0;
      gated_reg     <= 1'b0;
      edge_reg      <= 1'b0;
      rise_high_reg <= 1'b0;
    end else begin
      gate_reg      <= gate_en_i;
      gated_reg     <= gated_next;
      edge_reg      <= gated_next & ~gated_reg;
      rise_high_reg <= gate_en_i & ~gate_reg & sync2_reg;
    end
  end

  assign ifc.edge_pulse     = edge_reg;
  assign ifc.gated_level    = gated_reg;
  assign ifc.gate_rise_high = rise_high_reg;

endmodule : sysref_edge_detect

// ===== rtl/frame_lmfc_counter.sv
`timescale 1ns/1ps
module frame_lmfc_counter #(
  parameter int FRAME_CYC = align_pkg::FRAME_CYC_DEF,
  parameter int K         = align_pkg::K_DEF
) (
  input  wire logic clk_sys_i,
  input  wire logic rstn_i,
  align_if.cnt      ifc
);

  localparam int                        W        = align_pkg::CNT_W;
  localparam logic [align_pkg::CNT_W-1:0] CYC_LAST = W'(FRAME_CYC - 1);
  localparam logic [align_pkg::CNT_W-1:0] FRM_LAST = W'(K - 1);

  logic [W-1:0] cyc_reg;
  logic [W-1:0] frm_reg;
  logic [W-1:0] cyc_next;
  logic [W-1:0] frm_next;
  logic [W-1:0] base_cyc;
  logic [W-1:0] base_frm;
  logic         fstart_reg;
  logic         lstart_reg;

  // A load makes the present cycle phase zero
  always_comb begin
    base_cyc = ifc.load ? align_pkg::POS_RST : cyc_reg;
    base_frm = ifc.load ? align_pkg::POS_RST : frm_reg;
    if (base_cyc == CYC_LAST) begin
      cyc_next = align_pkg::POS_RST;
      frm_next = (base_frm == FRM_LAST) ? align_pkg::POS_RST : base_frm + W'(1);
    end else begin
      cyc_next = base_cyc + W'(1);
      frm_next = base_frm;
    end
  end

  // Reset gives the default phase
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cyc_reg    <= align_pkg::POS_RST;
      frm_reg    <= align_pkg::POS_RST;
      fstart_reg <= align_pkg::START_RST;
      lstart_reg <= align_pkg::START_RST;
    end else begin
      cyc_reg    <= cyc_next;
      frm_reg    <= frm_next;
      fstart_reg <= (cyc_next == align_pkg::POS_RST);
      lstart_reg <= (cyc_next == align_pkg::POS_RST) && (frm_next == align_pkg::POS_RST);
    end
  end

  assign ifc.cyc_pos     = cyc_reg;
  assign ifc.frame_pos   = frm_reg;
  assign ifc.frame_start = fstart_reg;
  assign ifc.lmfc_start  = lstart_reg;

endmodule : frame_lmfc_counter

// ===== rtl/sysref_frame_lmfc_alignment.sv
`timescale 1ns/1ps
// Behaviour
// - Incoming SYSREF passes an AND gate; gate enable decides detect or ignore.
// - Only the rising edge of gated SYSREF times frame and multiframe clocks.
// - Each detected edge is compared against the present frame and multiframe phase.
// - An edge matching the phase leaves phase and the serial link untouched.
// - A mismatching edge realigns both clocks and breaks the serial link.
// - Periodic SYSREF: first edge sets phase; later well-timed edges change nothing.
// - Gapped SYSREF: the first rising edge of each burst sets phase.
// - An edge inconsistent with the phase forces realignment; a badly timed (too short) pulse on phase only sets width_err_o.
// - One-shot SYSREF: its single rising edge establishes the phase.
// - Asynchronous SYSREF is accepted; latency then varies under two frames.
// - Without any SYSREF the block runs from its default phase.
// - Gate opened on a high input counts as an edge; next true edge realigns.
module sysref_frame_lmfc_alignment #(
  parameter int FRAME_CYC = align_pkg::FRAME_CYC_DEF,
  parameter int K         = align_pkg::K_DEF
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rstn_i,
  input  wire logic                        sysref_i,
  input  wire logic                        gate_en_i,
  output logic                             frame_tick_o,
  output logic                             lmfc_tick_o,
  output logic [align_pkg::CNT_W-1:0]      cyc_pos_o,
  output logic [align_pkg::CNT_W-1:0]      frame_pos_o,
  output logic                             sysref_edge_o,
  output logic                             realign_o,
  output logic                             link_break_o,
  output logic                             link_up_o,
  output logic                             established_o,
  output logic                             burst_first_o,
  output logic                             false_edge_o,
  output logic                             width_err_o,
  output logic [align_pkg::STAT_W-1:0]     edge_cnt_o,
  output logic [align_pkg::STAT_W-1:0]     realign_cnt_o
);

  // Pulse and gap limits are in sampling cycles
  localparam int                          SW         = align_pkg::STAT_W;
  localparam int                          GW         = align_pkg::GAP_W;
  localparam logic [align_pkg::GAP_W-1:0] MIN_HIGH   = GW'(align_pkg::MIN_PULSE_FRAMES * FRAME_CYC);
  localparam logic [align_pkg::GAP_W-1:0] GAP_CYC    = GW'(align_pkg::BURST_GAP_FRAMES * FRAME_CYC);
  localparam logic [align_pkg::GAP_W-1:0] GAP_SAT    = {align_pkg::GAP_W{1'b1}};

  // One bundle links the detector, the counters and this control logic
  align_if #(.CNT_W(align_pkg::CNT_W)) ifc ();

  // Phase ownership and link bring-up state
  align_pkg::phase_state_t phase_reg;
  align_pkg::link_state_t  link_reg;

  // Edge classification and status flops
  logic          mismatch;
  logic          match;
  logic          gated_prev_reg;
  logic          pulse_fall;
  logic [GW-1:0] high_cnt_reg;
  logic [GW-1:0] quiet_cnt_reg;
  logic          in_burst_reg;
  logic          established_reg;
  logic          realign_reg;
  logic          break_reg;
  logic          link_up_reg;
  logic          burst_first_reg;
  logic          false_edge_reg;
  logic          width_err_reg;
  logic [SW-1:0] edge_cnt_reg;
  logic [SW-1:0] realign_cnt_reg;

  sysref_edge_detect u_edge (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .sysref_i  (sysref_i),
    .gate_en_i (gate_en_i),
    .ifc       (ifc.det)
  );

  // Free running; only a mismatching edge reloads the phase
  frame_lmfc_counter #(
    .FRAME_CYC (FRAME_CYC),
    .K         (K)
  ) u_cnt (
    .clk_sys_i (clk_sys_i),
    .rstn_i    (rstn_i),
    .ifc       (ifc.cnt)
  );

  // Saturating increment, shared by both statistics counters
  function automatic logic [SW-1:0] sat_inc(input logic [SW-1:0] v);
    sat_inc = (v == align_pkg::STAT_MAX) ? v : v + SW'(1);
  endfunction : sat_inc

  // The edge is the phase-zero reference; lmfc_start marks the counters there
  assign match    = ifc.edge_pulse & ifc.lmfc_start;
  // Covers a first edge off the default phase, stray edges and mistimed edges alike
  assign mismatch = ifc.edge_pulse & ~ifc.lmfc_start;
  assign ifc.load = mismatch;

  // Phase ownership: default until the first edge, then SYSREF-derived
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      phase_reg <= align_pkg::PH_DEFAULT;
    end else begin
      unique case (phase_reg)
        // Any first edge leaves the default phase, aligned or not
        align_pkg::PH_DEFAULT: begin
          if (mismatch) begin
            phase_reg <= align_pkg::PH_REALIGNED;
          end else if (match) begin
            phase_reg <= align_pkg::PH_ESTABLISHED;
          end
        end
        // Aligned edges leave it here
        align_pkg::PH_ESTABLISHED: begin
          if (mismatch) begin
            phase_reg <= align_pkg::PH_REALIGNED;
          end
        end
        // Lasts one cycle unless mismatches follow back to back
        align_pkg::PH_REALIGNED: begin
          if (mismatch) begin
            phase_reg <= align_pkg::PH_REALIGNED;
          end else begin
            phase_reg <= align_pkg::PH_ESTABLISHED;
          end
        end
      endcase
    end
  end

  // Set on the first edge of any kind; held until reset
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      established_reg <= 1'b0;
    end else if (ifc.edge_pulse && phase_reg == align_pkg::PH_DEFAULT) begin
      established_reg <= 1'b1;
    end
  end

  // Link drops on realignment and comes back on the next multiframe boundary
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_reg <= align_pkg::LINK_DOWN;
    end else begin
      unique case (link_reg)
        // One cycle down so the break is seen before the wait
        align_pkg::LINK_DOWN: begin
          link_reg <= align_pkg::LINK_WAIT;
        end
        // A mismatch during bring-up restarts the wait from the new phase
        align_pkg::LINK_WAIT: begin
          if (mismatch) begin
            link_reg <= align_pkg::LINK_WAIT;
          end else if (ifc.lmfc_start) begin
            link_reg <= align_pkg::LINK_UP;
          end
        end
        // Aligned edges keep the link
        align_pkg::LINK_UP: begin
          if (mismatch) begin
            link_reg <= align_pkg::LINK_DOWN;
          end
        end
      endcase
    end
  end

  // Mirrors the transitions above so the pin is a flop, not a state decode
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      link_up_reg <= 1'b0;
    end else if (link_reg == align_pkg::LINK_UP && mismatch) begin
      link_up_reg <= 1'b0;
    end else if (link_reg == align_pkg::LINK_WAIT && ifc.lmfc_start && !mismatch) begin
      link_up_reg <= 1'b1;
    end else if (link_reg == align_pkg::LINK_DOWN) begin
      link_up_reg <= 1'b0;
    end
  end

  // Event pulses, one cycle each
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      realign_reg <= 1'b0;
      break_reg   <= 1'b0;
    end else begin
      realign_reg <= mismatch;
      break_reg   <= mismatch & (link_reg == align_pkg::LINK_UP);
    end
  end

  // Burst tracking: a long quiet stretch on the gated input closes a burst
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      quiet_cnt_reg <= align_pkg::GAP_RST;
    end else if (ifc.gated_level) begin
      quiet_cnt_reg <= align_pkg::GAP_RST;
    end else if (quiet_cnt_reg != GAP_SAT) begin
      quiet_cnt_reg <= quiet_cnt_reg + GW'(1);
    end
  end

  // Window runs from the fall, so a long pulse never ends its own burst
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      in_burst_reg    <= 1'b0;
      burst_first_reg <= 1'b0;
    end else begin
      burst_first_reg <= ifc.edge_pulse & ~in_burst_reg;
      // Edge wins over the gap timeout
      if (ifc.edge_pulse) begin
        in_burst_reg <= 1'b1;
      end else if (quiet_cnt_reg >= GAP_CYC) begin
        in_burst_reg <= 1'b0;
      end
    end
  end

  // Edge caused by opening the gate on a high input, not a true edge
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      false_edge_reg <= 1'b0;
    end else begin
      false_edge_reg <= ifc.gate_rise_high & ifc.edge_pulse;
    end
  end

  // Pulse-width check on the gated level; too short a pulse is badly timed
  assign pulse_fall = gated_prev_reg & ~ifc.gated_level;

  // Previous gated sample for the falling-edge detect
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gated_prev_reg <= 1'b0;
    end else begin
      gated_prev_reg <= ifc.gated_level;
    end
  end

  // Counts sampling cycles; a gate closed mid-pulse also shortens it
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      high_cnt_reg <= align_pkg::GAP_RST;
    end else if (!ifc.gated_level) begin
      high_cnt_reg <= align_pkg::GAP_RST;
    end else if (high_cnt_reg != GAP_SAT) begin
      high_cnt_reg <= high_cnt_reg + GW'(1);
    end
  end

  // Sticky until a fresh edge; a new short pulse wins over that clear
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      width_err_reg <= 1'b0;
    end else if (pulse_fall && high_cnt_reg < MIN_HIGH) begin
      width_err_reg <= 1'b1;
    end else if (ifc.edge_pulse) begin
      width_err_reg <= 1'b0;
    end
  end

  // Statistics for bring-up
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      edge_cnt_reg <= align_pkg::STAT_RST;
    end else if (ifc.edge_pulse) begin
      edge_cnt_reg <= sat_inc(edge_cnt_reg);
    end
  end

  // Saturates rather than wraps, so a busy source never reads as quiet
  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      realign_cnt_reg <= align_pkg::STAT_RST;
    end else if (mismatch) begin
      realign_cnt_reg <= sat_inc(realign_cnt_reg);
    end
  end

  // Every pin below is a flop, here or in a submodule
  assign frame_tick_o  = ifc.frame_start;
  assign lmfc_tick_o   = ifc.lmfc_start;
  assign cyc_pos_o     = ifc.cyc_pos;
  assign frame_pos_o   = ifc.frame_pos;
  assign sysref_edge_o = ifc.edge_pulse;
  assign realign_o     = realign_reg;
  assign link_break_o  = break_reg;
  assign link_up_o     = link_up_reg;
  assign established_o = established_reg;
  assign burst_first_o = burst_first_reg;
  assign false_edge_o  = false_edge_reg;
  assign width_err_o   = width_err_reg;
  assign edge_cnt_o    = edge_cnt_reg;
  assign realign_cnt_o = realign_cnt_reg;

endmodule : sysref_frame_lmfc_alignment

// ===== sim/align_checker.sv
`timescale 1ns/1ps
module align_checker #(
  parameter int FRAME_CYC = align_pkg::FRAME_CYC_DEF,
  parameter int K         = align_pkg::K_DEF
) (
  input wire logic                        clk_sys_i,
  input wire logic                        rstn_i,
  input wire logic                        gate_en_i,
  input wire logic                        frame_tick_o,
  input wire logic                        lmfc_tick_o,
  input wire logic [align_pkg::CNT_W-1:0] cyc_pos_o,
  input wire logic [align_pkg::CNT_W-1:0] frame_pos_o,
  input wire logic                        sysref_edge_o,
  input wire logic                        realign_o,
  input wire logic                        link_break_o,
  input wire logic                        link_up_o,
  input wire logic                        established_o,
  input wire logic                        false_edge_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rstn_i);

  gate_edge_a: assert property (
    sysref_edge_o |-> $past(gate_en_i)) else $error("edge with gate closed");
  one_edge_a: assert property (
    sysref_edge_o |=> !sysref_edge_o) else $error("edge held two cycles");
  edge_load_a: assert property (
    sysref_edge_o |=> cyc_pos_o == 1 && frame_pos_o == 0) else $error("edge not phase zero");
  misalign_a: assert property (
    sysref_edge_o && !lmfc_tick_o |=> realign_o && !link_up_o) else $error("no realign on mismatch");
  aligned_a: assert property (
    sysref_edge_o && lmfc_tick_o |=> !realign_o && (link_up_o || !$past(link_up_o)))
    else $error("aligned edge disturbed link");
  realign_cause_a: assert property (
    realign_o |-> $past(sysref_edge_o) && !$past(lmfc_tick_o)) else $error("realign without cause");
  break_cause_a: assert property (
    link_break_o |-> realign_o && $past(link_up_o)) else $error("break without link");
  false_edge_a: assert property (
    false_edge_o |-> $past(sysref_edge_o)) else $error("false edge flag alone");
  frame_wrap_a: assert property (
    cyc_pos_o == FRAME_CYC - 1 && !sysref_edge_o |=> frame_tick_o && cyc_pos_o == 0)
    else $error("frame count wrong");
  lmfc_wrap_a: assert property (
    cyc_pos_o == FRAME_CYC - 1 && frame_pos_o == K - 1 && !sysref_edge_o |=> lmfc_tick_o && frame_pos_o == 0)
    else $error("multiframe count wrong");
  link_rise_a: assert property (
    $rose(link_up_o) |-> $past(lmfc_tick_o)) else $error("link up off boundary");
  phase_kept_a: assert property (
    realign_o |-> established_o ##1 established_o) else $error("phase not established");
endmodule : align_checker

// ===== sim/sysref_source.sv
`timescale 1ns/1ps
module sysref_source (
  input  wire logic clk_i,
  output logic      sysref_o
);
  // Idle low keeps sampling quiet between bursts
  initial sysref_o = 1'b0;
  task automatic drive(input logic v);
    sysref_o = v;
  endtask : drive
  // Caller picks width; under two frames only when a fault is wanted
  task automatic pulse(input int wid);
    sysref_o = 1'b1;
    repeat (wid) @(posedge clk_i);
    #1 sysref_o = 1'b0;
  endtask : pulse
endmodule : sysref_source

// ===== sim/sysref_frame_lmfc_alignment_test.sv
`timescale 1ns/1ps
module sysref_frame_lmfc_alignment_test;
  localparam int FRAME_CYC = 2;
  localparam int K         = 16;
  localparam int MF        = FRAME_CYC * K;
  typedef struct {int cyc; logic re; logic brk; logic fe; logic bf;} note_t;
  logic                         clk_sys_i, rstn_i, gate_en_i, sysref_i;
  logic                         frame_tick_o, lmfc_tick_o, sysref_edge_o, realign_o, link_break_o;
  logic                         link_up_o, established_o, burst_first_o, false_edge_o, width_err_o;
  logic [align_pkg::CNT_W-1:0]  cyc_pos_o, frame_pos_o;
  logic [align_pkg::STAT_W-1:0] edge_cnt_o, realign_cnt_o;
  note_t                        notes[$];
  note_t                        cur;
  int                           num_errors = 0, compares = 0, cyc = 0, anchor = 0, up_at = MF + 1;
  int                           last_hi = -1000, nedge = 0, nre = 0;
  int                           seed = 32'hC96E;

  sysref_frame_lmfc_alignment #(.FRAME_CYC(FRAME_CYC), .K(K)) dut (
    .clk_sys_i, .rstn_i, .sysref_i, .gate_en_i, .frame_tick_o, .lmfc_tick_o, .cyc_pos_o, .frame_pos_o,
    .sysref_edge_o, .realign_o, .link_break_o, .link_up_o, .established_o, .burst_first_o,
    .false_edge_o, .width_err_o, .edge_cnt_o, .realign_cnt_o
  );
  sysref_source src (.clk_i(clk_sys_i), .sysref_o(sysref_i));

  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) cyc <= rstn_i ? cyc + 1 : 0;

  task automatic stop_test;
    if (num_errors == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : stop_test
  task automatic cmp_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic cmp_num(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : cmp_num
  task automatic step;
    @(posedge clk_sys_i);
    #1;
  endtask : step
  // Edge due in cycle e; the model phase moves only on a mismatch
  task automatic expect_edge(input int e, input logic fe);
    note_t n;
    n.cyc = e;
    n.re  = ((e - anchor) % MF) != 0;
    n.brk = n.re && e >= up_at;
    n.fe  = fe;
    n.bf  = (e - last_hi) > 200;
    if (n.re) begin
      anchor = e;
      up_at  = e + MF + 1;
      nre++;
    end
    nedge++;
    last_hi = e;
    notes.push_back(n);
  endtask : expect_edge
  task automatic wait_slot(input int lead, input int off);
    step();
    while ((cyc + lead - anchor) % MF != off) step();
  endtask : wait_slot
  task automatic shot(input int off, input int wid);
    wait_slot(3, off);
    expect_edge(cyc + 3, 1'b0);
    src.pulse(wid);
  endtask : shot

  always begin
    step();
    if (sysref_edge_o === 1'b1) begin
      if (notes.size() == 0) begin
        cmp_bit(sysref_edge_o, 1'b0);
      end else begin
        cur = notes.pop_front();
        cmp_num(cyc, cur.cyc);
        step();
        cmp_bit(realign_o, cur.re);
        cmp_bit(link_break_o, cur.brk);
        cmp_bit(false_edge_o, cur.fe);
        cmp_bit(burst_first_o, cur.bf);
        cmp_bit(established_o, 1'b1);
        cmp_num({frame_pos_o, cyc_pos_o}, 16'h0001);
      end
    end
  end

  initial begin
    repeat (5000) @(posedge clk_sys_i);
    num_errors++;
    stop_test();
  end

  initial begin
    rstn_i    = 1'b0;
    gate_en_i = 1'b0;
    repeat (12) @(posedge clk_sys_i);
    #1 rstn_i = 1'b1;
    repeat (40) step();
    cmp_bit(link_up_o, 1'b1);
    cmp_bit(established_o, 1'b0);
    cmp_num(frame_pos_o, (cyc % MF) / FRAME_CYC);
    cmp_num(cyc_pos_o, cyc % FRAME_CYC);
    src.pulse(6);
    repeat (100) step();
    gate_en_i = 1'b1;
    shot(1 + $unsigned($random(seed)) % (MF - 1), 4);
    for (int i = 0; i < 4; i++) begin
      repeat (MF * (i % 2)) step();
      shot(0, 4);
    end
    for (int i = 0; i < 3; i++) shot(1 + $unsigned($random(seed)) % (MF - 1), 4 + i);
    gate_en_i = 1'b0;
    repeat (300) step();
    src.drive(1'b1);
    repeat (5) step();
    wait_slot(1, 7);
    expect_edge(cyc + 1, 1'b1);
    gate_en_i = 1'b1;
    repeat (6) step();
    src.drive(1'b0);
    repeat (4) step();
    shot(5, 4);
    shot(0, 2);
    repeat (8) step();
    cmp_bit(width_err_o, 1'b1);
    shot(0, 4);
    repeat (8) step();
    cmp_bit(width_err_o, 1'b0);
    gate_en_i = 1'b0;
    repeat (10) step();
    cmp_num(edge_cnt_o, nedge);
    cmp_num(realign_cnt_o, nre);
    cmp_num(notes.size(), 0);
    stop_test();
  end
endmodule : sysref_frame_lmfc_alignment_test

bind sysref_frame_lmfc_alignment align_checker #(.FRAME_CYC(FRAME_CYC), .K(K)) chk (
  .clk_sys_i, .rstn_i, .gate_en_i, .frame_tick_o, .lmfc_tick_o, .cyc_pos_o, .frame_pos_o,
  .sysref_edge_o, .realign_o, .link_break_o, .link_up_o, .established_o, .false_edge_o
);
